// file: verilog/srl_spi_radio.sv
`timescale 1ns/1ns
module srl_spi_radio
  import srl_pkg::*;
#(
  parameter int RADIO_IDLE_STATE_TO_BURST_CYC = SRL_RADIO_IDLE_STATE_TO_BURST_CYC,
  parameter int RX_TX_SWAP_CYC = SRL_RX_TX_SWAP_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output srl_pins_s p1_pins_o,
  input wire logic p1_miso_i,
  output srl_pins_s radio_pins_o,
  input wire logic radio_miso_i,
  input wire logic radio_sel_n_i,
  output logic spi_busy_o,
  output logic spi_ready_o,
  input wire logic radio_activate_i,
  input wire logic tx_enable_i,
  input wire logic auto_retran_i,
  input wire logic tx_packet_done_i,
  input wire logic rx_addr_hit_i,
  input wire logic rx_packet_end_i,
  input wire logic rx_crc_ok_i,
  input wire logic [5:0] rx_payload_len_i,
  output logic radio_idle_state_o,
  output logic radio_mode_ready_o,
  output logic rx_packet_ready_o,
  output logic address_match_flag_o
);
  logic [7:0] shift_r;
  logic [1:0] route_r;
  logic [3:0] div_r;
  logic busy_r;
  logic ready_r;
  logic sck_r;
  logic samp_r;
  logic [2:0] bit_r;
  logic [5:0] hp_cnt_r;
  srl_radio_e state_r;
  srl_radio_e state_nxt;
  logic [SRL_TMR_W-1:0] tmr_r;
  logic [SRL_TMR_W-1:0] tmr_nxt;
  logic act_d_r;
  logic [5:0] rd_cnt_r;
  logic dr_r;
  logic am_r;

  wire wr_data = sfr_wr_i && (sfr_addr_i == SRL_ADDR_DATA);
  wire wr_route = sfr_wr_i && (sfr_addr_i == SRL_ADDR_ROUTE);
  wire wr_div = sfr_wr_i && (sfr_addr_i == SRL_ADDR_DIV);
  wire routed = (route_r == SRL_ROUTE_PORT1) || (route_r == SRL_ROUTE_RADIO);
  // A write during a transfer is dropped: the single buffer is in use.
  wire start = wr_data && routed && !busy_r;
  wire [5:0] half_per = (div_r == SRL_DIV_HALF_A || div_r == SRL_DIV_HALF_B) ? SRL_HP_2 :
                        (div_r == SRL_DIV_QUARTER) ? SRL_HP_4 :
                        (div_r == SRL_DIV_EIGHTH) ? SRL_HP_8 :
                        (div_r == SRL_DIV_16TH) ? SRL_HP_16 :
                        (div_r == SRL_DIV_32ND) ? SRL_HP_32 : SRL_HP_64;
  wire tick = busy_r && (hp_cnt_r == half_per - 6'h01);
  wire fall = tick && sck_r;
  wire done = fall && (bit_r == SRL_LAST_BIT);
  wire miso = (route_r == SRL_ROUTE_RADIO) ? radio_miso_i : p1_miso_i;
  wire on_p1 = (route_r == SRL_ROUTE_PORT1);
  wire on_radio = (route_r == SRL_ROUTE_RADIO);

  assign sfr_rdata_o = (sfr_addr_i == SRL_ADDR_DATA) ? shift_r :
                       (sfr_addr_i == SRL_ADDR_ROUTE) ? {6'h00, route_r} :
                       (sfr_addr_i == SRL_ADDR_DIV) ? {4'h0, div_r} : 8'h00;
  assign p1_pins_o = '{sck: sck_r && on_p1, sck_oe: on_p1, mosi: shift_r[7] && on_p1, mosi_oe: on_p1};
  assign radio_pins_o = '{sck: sck_r && on_radio, sck_oe: on_radio,
                          mosi: shift_r[7] && on_radio, mosi_oe: on_radio};
  assign spi_busy_o = busy_r;
  assign spi_ready_o = ready_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      route_r <= SRL_ROUTE_RST;
      div_r <= SRL_DIV_RST;
    end else begin
      if (wr_route) begin
        route_r <= sfr_wdata_i[1:0];
      end
      if (wr_div) begin
        div_r <= sfr_wdata_i[3:0];
      end
    end
  end

  // Mode 0 framing: sample on the rising edge, shift on the falling edge.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_r <= SRL_DATA_RST;
      busy_r <= 1'b0;
      ready_r <= 1'b0;
      sck_r <= 1'b0;
      samp_r <= 1'b0;
      bit_r <= 3'h0;
      hp_cnt_r <= 6'h00;
    end else begin
      ready_r <= done;
      hp_cnt_r <= (start || tick || !busy_r) ? 6'h00 : hp_cnt_r + 6'h01;
      if (start) begin
        shift_r <= sfr_wdata_i;
        busy_r <= 1'b1;
        sck_r <= 1'b0;
        bit_r <= 3'h0;
      end else if (wr_data && !busy_r) begin
        shift_r <= sfr_wdata_i;
      end else if (tick) begin
        sck_r <= !sck_r;
        if (!sck_r) begin
          samp_r <= miso;
        end else begin
          shift_r <= {shift_r[6:0], samp_r};
          bit_r <= bit_r + 3'h1;
          busy_r <= !done;
        end
      end
    end
  end

  // Radio sequencer; the wait timers bound the mode switching times.
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
    case (state_r)
      SRL_ST_IDLE: begin
        if (radio_activate_i && !act_d_r) begin
          state_nxt = tx_enable_i ? SRL_ST_TX_SW : SRL_ST_RX_SW;
          tmr_nxt = SRL_TMR_W'(RADIO_IDLE_STATE_TO_BURST_CYC - 1);
        end
      end
      SRL_ST_TX_SW, SRL_ST_RX_SW: begin
        if (tmr_r == '0) begin
          state_nxt = (state_r == SRL_ST_TX_SW) ? SRL_ST_TX : SRL_ST_RX;
        end
      end
      SRL_ST_TX: begin
        if (tx_packet_done_i) begin
          // Resend only while activate is held; otherwise wait in standby.
          state_nxt = (auto_retran_i && radio_activate_i) ? SRL_ST_TX : SRL_ST_IDLE;
        end else if (radio_activate_i && !tx_enable_i) begin
          state_nxt = SRL_ST_RX_SW;
          tmr_nxt = SRL_TMR_W'(RX_TX_SWAP_CYC - 1);
        end
      end
      SRL_ST_RX: begin
        if (!radio_activate_i) begin
          state_nxt = SRL_ST_IDLE;
        end else if (tx_enable_i) begin
          state_nxt = SRL_ST_TX_SW;
          tmr_nxt = SRL_TMR_W'(RX_TX_SWAP_CYC - 1);
        end
      end
      default: begin
        state_nxt = SRL_ST_IDLE;
      end
    endcase
  end

  // Readout counts bytes moved to the radio while its select is low.
  wire rd_byte = done && on_radio && !radio_sel_n_i;
  wire rd_all = rd_byte && dr_r && (rd_cnt_r + 6'h01 >= rx_payload_len_i);
  wire am_set = (state_r == SRL_ST_RX) && rx_addr_hit_i;
  wire dr_set = (state_r == SRL_ST_RX) && rx_packet_end_i && rx_crc_ok_i && am_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= SRL_ST_IDLE;
      tmr_r <= '0;
      act_d_r <= 1'b0;
      rd_cnt_r <= 6'h00;
      dr_r <= 1'b0;
      am_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      act_d_r <= radio_activate_i;
      rd_cnt_r <= (rd_all || dr_set) ? 6'h00 : (rd_byte && dr_r) ? rd_cnt_r + 6'h01 : rd_cnt_r;
      // A new event in the clearing cycle wins over the clear.
      dr_r <= dr_set || (dr_r && !rd_all);
      am_r <= am_set || (am_r && !rd_all);
    end
  end

  assign radio_idle_state_o = (state_r == SRL_ST_IDLE);
  assign radio_mode_ready_o = (state_r == SRL_ST_TX) || (state_r == SRL_ST_RX);
  assign rx_packet_ready_o = dr_r;
  assign address_match_flag_o = am_r;

  // Transfer length seen by the checks; a span this long is counted here rather than unrolled in a sequence.
  logic [9:0] busy_len_r;
  logic len_eighth_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_len_r <= 10'h000;
      len_eighth_r <= 1'b0;
    end else begin
      busy_len_r <= start ? 10'h000 : busy_r ? busy_len_r + 10'h001 : busy_len_r;
      len_eighth_r <= start ? (div_r == SRL_DIV_EIGHTH) && !wr_div : len_eighth_r && !wr_div;
    end
  end

  AST_NO_START_UNROUTED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (wr_data && !routed && !busy_r) |=> !busy_r) else $error("transfer started while unrouted");
  AST_NO_CLOCK_OFF: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (route_r == SRL_ROUTE_OFF) |-> !p1_pins_o.sck && !radio_pins_o.sck) else $error("clock while unused");
  AST_HALF_RATE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (start && div_r == SRL_DIV_HALF_B) |=> ##1 sck_r ##1 !sck_r) else $error("half rate wrong");
  AST_QUARTER_RATE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (start && div_r == SRL_DIV_QUARTER) |=> !sck_r ##1 !sck_r ##1 sck_r ##1 sck_r ##1 !sck_r)
    else $error("quarter rate wrong");
  AST_EIGHTH_LEN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ($fell(busy_r) && len_eighth_r) |-> busy_len_r == {SRL_HP_8, 4'h0}) else $error("eighth length wrong");
  AST_BYTE_DONE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (start && div_r == SRL_DIV_HALF_A && !wr_div) |=> ##16 ready_r) else $error("byte ready pulse late");
  AST_ONE_BUFFER: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (busy_r && wr_data && !tick) |=> $stable(shift_r) && $stable(bit_r)) else $error("buffer disturbed");
  AST_RADIO_IDLE_STATE_WAIT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_r == SRL_ST_IDLE && state_nxt == SRL_ST_TX_SW) |=> tmr_r == SRL_TMR_W'(RADIO_IDLE_STATE_TO_BURST_CYC - 1))
    else $error("standby wait wrong");
  AST_RETURN_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_r == SRL_ST_TX && tx_packet_done_i && !radio_activate_i) |=> radio_idle_state_o)
    else $error("no return to standby");
  AST_RETRANSMIT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_r == SRL_ST_TX && tx_packet_done_i && auto_retran_i && radio_activate_i) |=> state_r == SRL_ST_TX)
    else $error("retransmit dropped");
  AST_DR_NEEDS_AM: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(dr_r) |-> $past(am_r)) else $error("ready without match");
  AST_FLAGS_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (rd_all && !dr_set && !am_set) |=> !dr_r && !am_r) else $error("flags not cleared");

  COV_PORT1_BYTE: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) on_p1 && done);
  COV_RADIO_READOUT: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) rd_all);
  COV_SWAP: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    state_r == SRL_ST_RX && state_nxt == SRL_ST_TX_SW);
endmodule

// file: shared/srl_pkg.sv
// Notes on behaviour
// - Master only, one eight-bit data buffer, no queue behind it.
// - Clock, data out and data in go to port 1 low pins or the radio.
// - Port 2 bit 3 is the select reserved for the radio and converter.
// - Route 00 idle without clock, 01 port 1 pins, 10 internal radio.
// - Divider codes 0000 and 0001 give half the processor clock.
// - Divider code 0010 gives a quarter of the processor clock.
// - Code 0100 gives 1/16, 0101 gives 1/32, 0110 and above 1/64.
// - Burst receive to transmit and back completes within 550 us.
// - After a packet is sent the radio idles until the next activate pulse.
// - With retransmit on, the packet repeats while activate stays high.
// - Once packet ready rises the receive payload is valid for readout.
// - Full payload readout over the serial link clears both radio flags.
// - Packet ready rises only for a matching address with a good checksum.
// - Address match rises when the incoming address equals the own identity.
package srl_pkg;
  localparam logic [7:0] SRL_ADDR_DATA = 8'hB2;
  localparam logic [7:0] SRL_ADDR_ROUTE = 8'hB3;
  localparam logic [7:0] SRL_ADDR_DIV = 8'hB4;
  localparam logic [7:0] SRL_DATA_RST = 8'h00;
  localparam logic [1:0] SRL_ROUTE_RST = 2'h0;
  localparam logic [3:0] SRL_DIV_RST = 4'h0;
  localparam logic [1:0] SRL_ROUTE_OFF = 2'h0;
  localparam logic [1:0] SRL_ROUTE_PORT1 = 2'h1;
  localparam logic [1:0] SRL_ROUTE_RADIO = 2'h2;
  localparam logic [3:0] SRL_DIV_HALF_A = 4'h0;
  localparam logic [3:0] SRL_DIV_HALF_B = 4'h1;
  localparam logic [3:0] SRL_DIV_QUARTER = 4'h2;
  localparam logic [3:0] SRL_DIV_EIGHTH = 4'h3;
  localparam logic [3:0] SRL_DIV_16TH = 4'h4;
  localparam logic [3:0] SRL_DIV_32ND = 4'h5;
  // Half periods of the serial clock in processor cycles.
  localparam logic [5:0] SRL_HP_2 = 6'h01;
  localparam logic [5:0] SRL_HP_4 = 6'h02;
  localparam logic [5:0] SRL_HP_8 = 6'h04;
  localparam logic [5:0] SRL_HP_16 = 6'h08;
  localparam logic [5:0] SRL_HP_32 = 6'h10;
  localparam logic [5:0] SRL_HP_64 = 6'h20;
  localparam logic [2:0] SRL_LAST_BIT = 3'h7;
  localparam int SRL_CLK_MHZ = 100;
  localparam int SRL_RADIO_IDLE_STATE_TO_BURST_US = 650;
  localparam int SRL_RX_TX_SWAP_US = 550;
  localparam int SRL_RADIO_IDLE_STATE_TO_BURST_CYC = SRL_RADIO_IDLE_STATE_TO_BURST_US * SRL_CLK_MHZ;
  localparam int SRL_RX_TX_SWAP_CYC = SRL_RX_TX_SWAP_US * SRL_CLK_MHZ;
  localparam int SRL_TMR_W = 17;

  typedef enum logic [4:0] {
    SRL_ST_IDLE = 5'h01,
    SRL_ST_TX_SW = 5'h02,
    SRL_ST_TX = 5'h04,
    SRL_ST_RX_SW = 5'h08,
    SRL_ST_RX = 5'h10
  } srl_radio_e;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
  } srl_pins_s;
endpackage

// file: tb/srl_slave_model.sv
`timescale 1ns/1ns
// Mode 0 slave on the far side. A deselected data line shows the inverse of its last bit.
module srl_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_n_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  logic [7:0] sh_r = 8'h00;
  logic [7:0] rx_r = 8'h00;
  logic sel_q = 1'b0;
  // One process owns the shift register, so a load and a shift can never race each other.
  always @(sel_n_i or negedge sck_i) begin
    if (sel_n_i) begin
      sel_q = 1'b0;
    end else if (!sel_q) begin
      sh_r = tx_i;
      sel_q = 1'b1;
    end else begin
      sh_r = {sh_r[6:0], ~sh_r[7]};
    end
  end
  always @(posedge sck_i) begin
    if (!sel_n_i) rx_r = {rx_r[6:0], mosi_i};
  end
  assign rx_o = rx_r;
  assign miso_o = sel_n_i ? ~sh_r[7] : sh_r[7];
endmodule

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
  import srl_pkg::*;
  logic clk_sys_i, rstn_i, sfr_wr, p1_sel_n, radio_sel_n, act, tx_en, retran, crc_ok;
  logic p1_miso, radio_miso, busy, ready, idle, mode_rdy, dr, am;
  logic [7:0] addr, wdata, rdata, stx, p1_rx, rd_rx;
  logic [3:0] code;
  logic [2:0] pl;
  logic [5:0] plen;
  srl_pins_s p1_pins, radio_pins;
  int fails = 0;
  int total_checks = 0;
  int n;
  int hp_tab[8] = '{1, 1, 2, 4, 8, 16, 32, 32};
  // Short radio waits keep the run brief; the expected counts below follow from them.
  localparam int RADIO_IDLE_STATE_CYC = 20;
  localparam int SWAP_CYC = 10;
  srl_spi_radio #(.RADIO_IDLE_STATE_TO_BURST_CYC(RADIO_IDLE_STATE_CYC), .RX_TX_SWAP_CYC(SWAP_CYC)) dut_u (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sfr_addr_i(addr), .sfr_wr_i(sfr_wr), .sfr_wdata_i(wdata),
    .sfr_rdata_o(rdata), .p1_pins_o(p1_pins), .p1_miso_i(p1_miso), .radio_pins_o(radio_pins),
    .radio_miso_i(radio_miso), .radio_sel_n_i(radio_sel_n), .spi_busy_o(busy), .spi_ready_o(ready),
    .radio_activate_i(act), .tx_enable_i(tx_en), .auto_retran_i(retran), .tx_packet_done_i(pl[0]),
    .rx_addr_hit_i(pl[1]), .rx_packet_end_i(pl[2]), .rx_crc_ok_i(crc_ok), .rx_payload_len_i(plen),
    .radio_idle_state_o(idle), .radio_mode_ready_o(mode_rdy), .rx_packet_ready_o(dr), .address_match_flag_o(am));
  srl_slave_model p1_u (.sck_i(p1_pins.sck), .mosi_i(p1_pins.mosi), .sel_n_i(p1_sel_n), .tx_i(stx),
    .miso_o(p1_miso), .rx_o(p1_rx));
  srl_slave_model radio_u (.sck_i(radio_pins.sck), .mosi_i(radio_pins.mosi), .sel_n_i(radio_sel_n), .tx_i(stx),
    .miso_o(radio_miso), .rx_o(rd_rx));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #1;
    addr = a;
    wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk_sys_i) #1;
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i) #1;
    addr = a;
    @(posedge clk_sys_i) #1;
    chk("read", {8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic wait_hi(input bit which);
    n = 0;
    do begin
      @(posedge clk_sys_i) #1;
      n++;
    end while (!(which ? mode_rdy : ready) && n < 5000);
    if (n >= 5000) fails++;
  endtask
  // The extra edge is margin only; every flag is registered on the edge that samples the pulse.
  task automatic pulse(input int k);
    @(posedge clk_sys_i) #1;
    pl[k] = 1'b1;
    @(posedge clk_sys_i) #1;
    pl = 3'h0;
    @(posedge clk_sys_i) #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #400000;
    fails++;
    final_report();
  end
  initial begin
    rstn_i = 1'b0;
    {sfr_wr, act, tx_en, retran, crc_ok} = 5'h00;
    {p1_sel_n, radio_sel_n} = 2'h3;
    {addr, wdata, stx, pl, code} = 31'h0;
    plen = 6'h02;
    repeat (8) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    rd(SRL_ADDR_DATA, SRL_DATA_RST);
    rd(SRL_ADDR_ROUTE, 8'h00);
    rd(SRL_ADDR_DIV, 8'h00);
    rd(8'hB5, 8'h00);
    wr(SRL_ADDR_DATA, 8'h5A);
    rd(SRL_ADDR_DATA, 8'h5A);
    chk("idle_lines", {11'h0, busy, p1_pins}, 16'h0000);
    wr(SRL_ADDR_ROUTE, SRL_ROUTE_PORT1);
    rd(SRL_ADDR_ROUTE, 8'h01);
    chk("route_oe", {14'h0, p1_pins.sck_oe, radio_pins.sck_oe}, 16'h0002);
    for (int c = 0; c < 8; c++) begin
      code = (c == 7) ? 4'hF : c[3:0];
      stx = 8'h3C ^ {4'h0, code};
      wr(SRL_ADDR_DIV, {4'h0, code});
      rd(SRL_ADDR_DIV, {4'h0, code});
      p1_sel_n = 1'b0;
      wr(SRL_ADDR_DATA, 8'hC3 + {4'h0, code});
      chk("busy", {15'h0, busy}, 16'h0001);
      // A second write lands while busy and must be dropped; the call spends two edges of the count.
      if (code == 4'h3) wr(SRL_ADDR_DATA, 8'hFF);
      wait_hi(1'b0);
      n += (code == 4'h3) ? 2 : 0;
      chk("cycles", n[15:0], 16'(16 * hp_tab[c]));
      rd(SRL_ADDR_DATA, stx);
      chk("slave_rx", {8'h00, p1_rx}, {8'h00, 8'hC3 + {4'h0, code}});
      p1_sel_n = 1'b1;
    end
    wr(SRL_ADDR_ROUTE, SRL_ROUTE_RADIO);
    tx_en = 1'b1;
    retran = 1'b1;
    act = 1'b1;
    wait_hi(1'b1);
    chk("radio_idle_state_to_tx", n[15:0], 16'(RADIO_IDLE_STATE_CYC + 1));
    tx_en = 1'b0;
    wait_hi(1'b1);
    chk("tx_to_rx", n[15:0], 16'(SWAP_CYC + 1));
    tx_en = 1'b1;
    wait_hi(1'b1);
    chk("rx_to_tx", n[15:0], 16'(SWAP_CYC + 1));
    pulse(0);
    chk("retran", {15'h0, idle}, 16'h0000);
    retran = 1'b0;
    pulse(0);
    repeat (30) @(posedge clk_sys_i);
    #1 chk("standby", {14'h0, idle, mode_rdy}, 16'h0002);
    act = 1'b0;
    tx_en = 1'b0;
    @(posedge clk_sys_i) #1 act = 1'b1;
    wait_hi(1'b1);
    chk("radio_idle_state_to_rx", n[15:0], 16'(RADIO_IDLE_STATE_CYC + 1));
    crc_ok = 1'b1;
    pulse(2);
    chk("dr_no_am", {15'h0, dr}, 16'h0000);
    pulse(1);
    chk("am_set", {15'h0, am}, 16'h0001);
    crc_ok = 1'b0;
    pulse(2);
    chk("dr_bad_crc", {15'h0, dr}, 16'h0000);
    crc_ok = 1'b1;
    pulse(2);
    chk("dr_set", {15'h0, dr}, 16'h0001);
    act = 1'b0;
    radio_sel_n = 1'b0;
    wr(SRL_ADDR_DATA, 8'h11);
    wait_hi(1'b0);
    rd(SRL_ADDR_DATA, stx);
    chk("dr_hold", {14'h0, dr, am}, 16'h0003);
    wr(SRL_ADDR_DATA, 8'h22);
    wait_hi(1'b0);
    @(posedge clk_sys_i) #1;
    chk("flags_clear", {14'h0, dr, am}, 16'h0000);
    chk("radio_rx", {8'h00, rd_rx}, 16'h0022);
    rd(SRL_ADDR_DATA, ~stx);
    final_report();
  end
endmodule
